// ### inc/adc_out_pkg.sv
package adc_out_pkg;

    // output divide ratio selected by the mode pins
    typedef enum logic [1:0] {
        DIV_BY_1 = 2'b00,
        DIV_BY_2 = 2'b01,
        DIV_BY_5 = 2'b11
    } div_ratio_t;

    // converter code constants
    localparam int CODE_W = 8;
    localparam logic [CODE_W-1:0] CODE_FULL_SCALE = 8'hff;
    localparam logic [CODE_W-1:0] CODE_MID_SCALE = 8'h80;
    localparam logic [CODE_W-1:0] CODE_ZERO_SCALE = 8'h00;
    localparam int CODE_HALF_SPAN = 128;
    // level held on a port that carries no data
    localparam logic [CODE_W-1:0] IDLE_WORD = 8'h00;

    // nominal differential full scale, in millivolts
    localparam int FULL_SCALE_MV = 270;
    // analog inputs are signed millivolt words of this default width
    localparam int ANALOG_W = 12;

    // pipeline latency from hold to output stage, in input clocks
    localparam int PIPE_LATENCY = 4;

    // input clock and divide counts
    localparam int REF_CLK_MHZ = 250;
    localparam int DIV2_COUNT = 2;
    localparam int DIV5_COUNT = 5;
    localparam int DIV_CNT_W = 3;
    // counter phase on which output words are loaded; words change at the divided clock fall (div2) or half a cycle after it (div5)
    localparam logic [DIV_CNT_W-1:0] DIV2_LOAD_PHASE = 3'h0;
    localparam logic [DIV_CNT_W-1:0] DIV5_LOAD_PHASE = 3'h2;
    // last counter phase with the divided clock high
    localparam logic [DIV_CNT_W-1:0] DIV5_HIGH_LAST = 3'h1;

    // mode pins to divide ratio; ratio pin only counts when dividing
    function automatic div_ratio_t decode_ratio(input logic div_sel, input logic ratio_sel);
        if (!div_sel) begin
            decode_ratio = DIV_BY_1;
        end else if (ratio_sel) begin
            decode_ratio = DIV_BY_5;
        end else begin
            decode_ratio = DIV_BY_2;
        end
    endfunction : decode_ratio

endpackage : adc_out_pkg

// ### logic/out_clock_div.sv
`timescale 1ns/1ps
`default_nettype none
module out_clock_div (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire adc_out_pkg::div_ratio_t ratio_i,
    output logic load_o,
    output logic clock_o
);
    import adc_out_pkg::*;

    logic [DIV_CNT_W-1:0] cnt;
    logic [DIV_CNT_W-1:0] cnt_last;
    logic [DIV_CNT_W-1:0] next_cnt;
    logic [DIV_CNT_W-1:0] load_phase;
    logic q_pos;
    logic q_neg;
    logic next_q_pos;
    logic div_clock;

    // counter wraps at the ratio; an out-of-range count after a ratio change wraps at once
    assign cnt_last = (ratio_i == DIV_BY_5) ? DIV_CNT_W'(DIV5_COUNT - 1) : DIV_CNT_W'(DIV2_COUNT - 1);
    assign next_cnt = (ratio_i == DIV_BY_1 || cnt >= cnt_last) ? '0 : cnt + 3'h1;
    assign load_phase = (ratio_i == DIV_BY_5) ? DIV5_LOAD_PHASE : DIV2_LOAD_PHASE;
    assign load_o = (ratio_i == DIV_BY_1) || (cnt == load_phase);

    // divided clock high at the top of each period
    assign next_q_pos = (ratio_i == DIV_BY_5) ? (next_cnt <= DIV5_HIGH_LAST) : (next_cnt == '0);

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cnt <= '0;
            q_pos <= 1'b0;
        end else begin
            cnt <= next_cnt;
            q_pos <= next_q_pos;
        end
    end

    // stretch to the next falling edge makes 2.5 of 5 cycles high only when the input duty is 50%
    always_ff @(negedge clk_i) begin
        if (rst_i) begin
            q_neg <= 1'b0;
        end else begin
            q_neg <= q_pos;
        end
    end

    // div2 needs no stretch: one high cycle of two is already even
    assign div_clock = (ratio_i == DIV_BY_5) ? (q_pos | q_neg) : q_pos; // RQ12
    // divide-by-1 forwards the input clock itself, keeping its duty cycle
    assign clock_o = (ratio_i == DIV_BY_1) ? clk_i : div_clock; // RQ13

endmodule : out_clock_div
`default_nettype wire

// ### logic/adc_output_path_mode_ctrl.sv
`timescale 1ns/1ps
`default_nettype none
// What this block does
// RQ1 - +270 mV differential gives code ff
// RQ2 - zero difference gives code 80
// RQ3 - -270 mV differential gives code 00
// RQ4 - code saturates at both ends, never wraps
// RQ5 - divide-by-1: primary only, ratio pin ignored
// RQ6 - divide-by-1 mirrored: secondary equals primary
// RQ7 - demux: primary newest, secondary previous sample
// RQ8 - demux ports update together at half rate
// RQ9 - divide-by-2 mirrored: same sample, alternate discarded
// RQ10 - divide-by-5: primary every fifth clock only
// RQ11 - divide-by-5 mirrored: both ports every fifth
// RQ12 - divided output clock has exact 50% duty at div2, and at div5 with 50% input duty
// RQ13 - divide-by-1 clock keeps input duty cycle
// RQ14 - output clock derived from input clock
// RQ15 - input clock must not exceed 250 MHz
// RQ16 - sample held on falling input clock edge
// RQ17 - fixed pipeline latency before output ports
// RQ18 - mode pins held static during operation
// RQ19 - inactive port held at constant level
module adc_output_path_mode_ctrl #(
    parameter int ANALOG_WIDTH = adc_out_pkg::ANALOG_W,
    parameter int FULL_SCALE = adc_out_pkg::FULL_SCALE_MV,
    parameter int LATENCY = adc_out_pkg::PIPE_LATENCY
) (
    input wire logic REF_CLK_I,
    input wire logic RESET_I,
    input wire logic signed [ANALOG_WIDTH-1:0] ANALOG_IN_POS_I,
    input wire logic signed [ANALOG_WIDTH-1:0] ANALOG_IN_NEG_I,
    input wire logic DIVIDE_SELECT_I,
    input wire logic RATIO_SELECT_I,
    input wire logic MIRROR_SELECT_I,
    output logic [adc_out_pkg::CODE_W-1:0] PRIMARY_OUT_WORD_O,
    output logic [adc_out_pkg::CODE_W-1:0] SECONDARY_OUT_WORD_O,
    output logic FORWARDED_OUT_CLOCK_O,
    output logic FORWARDED_OUT_CLOCK_N_O
);
    import adc_out_pkg::*;

    // arithmetic width for difference times half span
    localparam int DIFF_W = ANALOG_WIDTH + 1;
    localparam int SCALE_W = DIFF_W + 8;

    // refuse settings the quantiser or pipeline cannot serve
    if (ANALOG_WIDTH < 10 || ANALOG_WIDTH > 20) begin : g_bad_width
        $error("analog width must be 10 to 20 bits");
    end
    if (FULL_SCALE < 1 || FULL_SCALE >= (1 << (ANALOG_WIDTH - 1))) begin : g_bad_scale
        $error("full scale must be positive and fit the analog width");
    end
    if (LATENCY < 2 || LATENCY > 16) begin : g_bad_latency
        $error("latency must be 2 to 16 clocks");
    end

    // package counts must fit the divider counter and keep each load inside its period
    if (DIV5_COUNT >= (1 << DIV_CNT_W) || DIV2_COUNT >= (1 << DIV_CNT_W)) begin : g_bad_div_width
        $error("divider counter too narrow for the divide counts");
    end
    if (int'(DIV2_LOAD_PHASE) >= DIV2_COUNT || int'(DIV5_LOAD_PHASE) >= DIV5_COUNT) begin : g_bad_load_phase
        $error("load phase outside its divide period");
    end
    // the clamp and the mid-scale offset assume the half span is half the code range
    if (CODE_HALF_SPAN * 2 != (1 << CODE_W)) begin : g_bad_span
        $error("half span must be half of the code range");
    end

    localparam logic signed [SCALE_W-1:0] FULL_SCALE_W = SCALE_W'(FULL_SCALE);
    localparam logic signed [SCALE_W-1:0] HALF_SPAN_W = SCALE_W'(CODE_HALF_SPAN);
    localparam logic signed [SCALE_W-1:0] CODE_MAX_W = SCALE_W'(CODE_FULL_SCALE);

    logic signed [ANALOG_WIDTH-1:0] held_pos;
    logic signed [ANALOG_WIDTH-1:0] held_neg;
    logic signed [DIFF_W-1:0] diff_mv;
    logic signed [SCALE_W-1:0] diff_scaled;
    logic signed [SCALE_W-1:0] code_wide;
    logic [CODE_W-1:0] code_sat;
    logic [CODE_W-1:0] pipe [LATENCY-1];
    logic [CODE_W-1:0] newest;
    logic [CODE_W-1:0] previous;
    div_ratio_t ratio;
    logic load;
    logic out_clock;
    logic next_primary_sel;
    logic [CODE_W-1:0] next_primary;
    logic [CODE_W-1:0] next_secondary;
    logic [2:0] mode_pins;
    logic [2:0] last_mode_pins;
    logic mode_changed;
    logic div_restart;

    // track/hold: inputs frozen at the falling clock edge
    always_ff @(negedge REF_CLK_I) begin
        if (RESET_I) begin
            held_pos <= '0;
            held_neg <= '0;
        end else begin
            held_pos <= ANALOG_IN_POS_I; // RQ16
            held_neg <= ANALOG_IN_NEG_I; // RQ16
        end
    end

    // linear map of the difference onto 256 codes around mid scale
    assign diff_mv = DIFF_W'(held_pos) - DIFF_W'(held_neg);
    assign diff_scaled = SCALE_W'(diff_mv) * HALF_SPAN_W;
    // +full scale lands on 256 and is clipped below to ff
    assign code_wide = (diff_scaled / FULL_SCALE_W) + HALF_SPAN_W; // RQ1 RQ2 RQ3

    // clamp instead of truncating, so overrange cannot wrap to the far end
    assign code_sat = (code_wide > CODE_MAX_W) ? CODE_FULL_SCALE :
                      (code_wide < 0) ? CODE_ZERO_SCALE :
                      code_wide[CODE_W-1:0]; // RQ4

    // fixed-depth pipeline; LATENCY-1 stages plus the output register give the latency
    always_ff @(posedge REF_CLK_I) begin
        if (RESET_I) begin
            pipe[0] <= CODE_MID_SCALE;
        end else begin
            pipe[0] <= code_sat; // RQ17
        end
    end

    for (genvar s = 1; s < LATENCY - 1; s++) begin : g_pipe
        always_ff @(posedge REF_CLK_I) begin
            if (RESET_I) begin
                pipe[s] <= CODE_MID_SCALE;
            end else begin
                pipe[s] <= pipe[s-1]; // RQ17
            end
        end
    end

    assign newest = pipe[LATENCY-2];

    // one-sample history for the demultiplexer pair
    always_ff @(posedge REF_CLK_I) begin
        if (RESET_I) begin
            previous <= CODE_MID_SCALE;
        end else begin
            previous <= newest;
        end
    end

    // ratio pin only matters when dividing
    assign ratio = decode_ratio(DIVIDE_SELECT_I, RATIO_SELECT_I); // RQ5

    // pins should stay static; a change restarts the divider so its phase realigns at once
    assign mode_pins = {DIVIDE_SELECT_I, RATIO_SELECT_I, MIRROR_SELECT_I};
    assign mode_changed = mode_pins != last_mode_pins;
    assign div_restart = RESET_I || mode_changed; // RQ18

    // pin history, loaded in reset too so release never looks like a change
    always_ff @(posedge REF_CLK_I) begin
        last_mode_pins <= mode_pins;
    end

    out_clock_div u_div (
        .clk_i(REF_CLK_I),
        .rst_i(div_restart),
        .ratio_i(ratio), // RQ18
        .load_o(load),
        .clock_o(out_clock)
    );

    // both clock phases come from the divider output, built from the input clock
    assign FORWARDED_OUT_CLOCK_O = out_clock; // RQ14
    assign FORWARDED_OUT_CLOCK_N_O = ~out_clock; // RQ14

    // samples between loads are dropped, not queued
    assign next_primary_sel = load; // RQ10
    assign next_primary = newest; // RQ5 RQ7

    // secondary: previous sample in demux, copy when mirrored, idle otherwise
    assign next_secondary = MIRROR_SELECT_I ? newest : // RQ6 RQ9 RQ11
                            (ratio == DIV_BY_2) ? previous : // RQ7
                            IDLE_WORD; // RQ5 RQ10 RQ19

    // both ports load on the same edge, so the pair is always coherent
    always_ff @(posedge REF_CLK_I) begin
        if (RESET_I) begin
            PRIMARY_OUT_WORD_O <= CODE_MID_SCALE;
            SECONDARY_OUT_WORD_O <= IDLE_WORD;
        end else if (next_primary_sel) begin
            PRIMARY_OUT_WORD_O <= next_primary; // RQ8 RQ9 RQ10 RQ11
            SECONDARY_OUT_WORD_O <= next_secondary; // RQ8 RQ19
        end
    end

endmodule : adc_output_path_mode_ctrl
`default_nettype wire

// ### testbench/adc_out_sva.sv
`timescale 1ns/1ps
`default_nettype none
module adc_out_sva
    import adc_out_pkg::*;
(
    input wire logic REF_CLK_I,
    input wire logic RESET_I,
    input wire logic DIVIDE_SELECT_I,
    input wire logic RATIO_SELECT_I,
    input wire logic MIRROR_SELECT_I,
    input wire logic [CODE_W-1:0] PRIMARY_OUT_WORD_O,
    input wire logic [CODE_W-1:0] SECONDARY_OUT_WORD_O,
    input wire logic FORWARDED_OUT_CLOCK_O,
    input wire logic FORWARDED_OUT_CLOCK_N_O
);
    logic [2:0] last_mode;
    logic [4:0] quiet;
    wire logic [2:0] mode = {DIVIDE_SELECT_I, RATIO_SELECT_I, MIRROR_SELECT_I};
    wire logic ok = quiet == 5'h1f;
    wire logic d2 = ok && DIVIDE_SELECT_I && !RATIO_SELECT_I;
    wire logic d5 = ok && DIVIDE_SELECT_I && RATIO_SELECT_I;
    // output is undefined right after a mode change, so settle first
    always_ff @(posedge REF_CLK_I) begin
        last_mode <= mode;
        quiet <= (RESET_I || mode != last_mode) ? 5'h00 : quiet + {4'h0, quiet != 5'h1f};
    end
    default clocking cb @(posedge REF_CLK_I);
    endclocking
    default disable iff (RESET_I);
    chk_clock_pair_inverse: assert property (FORWARDED_OUT_CLOCK_N_O != FORWARDED_OUT_CLOCK_O)
        else $error("clock pair not inverse");
    chk_single_port_idle: assert property (ok && !DIVIDE_SELECT_I && !MIRROR_SELECT_I
        |-> SECONDARY_OUT_WORD_O == IDLE_WORD) else $error("secondary active in divide by 1");
    chk_mirror_ports_equal: assert property (ok && MIRROR_SELECT_I
        |-> PRIMARY_OUT_WORD_O == SECONDARY_OUT_WORD_O) else $error("mirrored ports differ");
    chk_div5_port_idle: assert property (d5 && !MIRROR_SELECT_I
        |-> SECONDARY_OUT_WORD_O == IDLE_WORD) else $error("secondary active in divide by 5");
    chk_div2_clock_toggle: assert property (d2 |-> FORWARDED_OUT_CLOCK_O != $past(FORWARDED_OUT_CLOCK_O))
        else $error("half rate clock not toggling");
    chk_div2_data_hold: assert property (d2 && ($changed(PRIMARY_OUT_WORD_O) || $changed(SECONDARY_OUT_WORD_O))
        |=> $stable(PRIMARY_OUT_WORD_O) && $stable(SECONDARY_OUT_WORD_O)) else $error("demux ports not held");
    chk_div5_clock_period: assert property (d5 && $rose(FORWARDED_OUT_CLOCK_O)
        |=> !$rose(FORWARDED_OUT_CLOCK_O) [*4] ##1 $rose(FORWARDED_OUT_CLOCK_O)) else $error("fifth rate clock period");
    chk_div5_data_hold: assert property (d5 && $changed(PRIMARY_OUT_WORD_O)
        |=> $stable(PRIMARY_OUT_WORD_O) [*4]) else $error("fifth rate data not held");
    chk_div1_clock_follow: assert property (@(negedge REF_CLK_I) disable iff (RESET_I)
        !DIVIDE_SELECT_I |-> FORWARDED_OUT_CLOCK_O) else $error("full rate clock not following");
    chk_div1_clock_low: assert property (ok && !DIVIDE_SELECT_I |-> !FORWARDED_OUT_CLOCK_O)
        else $error("full rate clock high at rising edge");
    cover property (d2 && !MIRROR_SELECT_I && $changed(SECONDARY_OUT_WORD_O));
    cover property (d5 && MIRROR_SELECT_I && $changed(PRIMARY_OUT_WORD_O));
    cover property (ok && !DIVIDE_SELECT_I && MIRROR_SELECT_I && $changed(PRIMARY_OUT_WORD_O));
endmodule : adc_out_sva
bind adc_output_path_mode_ctrl adc_out_sva chk (.REF_CLK_I(REF_CLK_I), .RESET_I(RESET_I),
    .DIVIDE_SELECT_I(DIVIDE_SELECT_I), .RATIO_SELECT_I(RATIO_SELECT_I), .MIRROR_SELECT_I(MIRROR_SELECT_I),
    .PRIMARY_OUT_WORD_O(PRIMARY_OUT_WORD_O), .SECONDARY_OUT_WORD_O(SECONDARY_OUT_WORD_O),
    .FORWARDED_OUT_CLOCK_O(FORWARDED_OUT_CLOCK_O), .FORWARDED_OUT_CLOCK_N_O(FORWARDED_OUT_CLOCK_N_O));
`default_nettype wire

// ### testbench/out_capture_model.sv
`timescale 1ns/1ps
`default_nettype none
module out_capture_model (
    input wire logic clock_i,
    output int rises_o
);
    initial rises_o = 0;
    // downstream capture is timed only by the forwarded clock
    always @(posedge clock_i) begin
        rises_o <= rises_o + 1;
    end
endmodule : out_capture_model
`default_nettype wire

// ### testbench/test_adc_output_path_mode_ctrl.sv
`timescale 1ns/1ps
`default_nettype none
module test_adc_output_path_mode_ctrl;
    import adc_out_pkg::*;
    localparam int L = 4;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic signed [11:0] pos = 12'h000;
    logic signed [11:0] neg = 12'h000;
    logic dv = 1'b0;
    logic rt = 1'b0;
    logic mr = 1'b0;
    logic [7:0] pri;
    logic [7:0] sec;
    logic fwd;
    int rises;
    int fails = 0;
    int cmp_count = 0;
    int i = 0;
    int h[$];
    int tbl[5] = '{270, 0, -270, 400, -500};
    adc_output_path_mode_ctrl #(.LATENCY(L)) uut (.REF_CLK_I(clk), .RESET_I(rst), .ANALOG_IN_POS_I(pos),
        .ANALOG_IN_NEG_I(neg), .DIVIDE_SELECT_I(dv), .RATIO_SELECT_I(rt), .MIRROR_SELECT_I(mr),
        .PRIMARY_OUT_WORD_O(pri), .SECONDARY_OUT_WORD_O(sec), .FORWARDED_OUT_CLOCK_O(fwd),
        .FORWARDED_OUT_CLOCK_N_O());
    out_capture_model far (.clock_i(fwd), .rises_o(rises));
    // 250 MHz input clock
    always #2 clk = ~clk;
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            fails++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic final_report();
        if (fails == 0 && cmp_count > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : final_report
    // ideal quantiser: truncation toward zero, saturating at both ends
    function automatic int code(input int d);
        int c;
        c = d * CODE_HALF_SPAN / FULL_SCALE_MV + CODE_HALF_SPAN;
        return c > 255 ? 255 : (c < 0 ? 0 : c);
    endfunction : code
    // record the sample held at this falling edge, then drive the next
    task automatic step();
        @(negedge clk);
        h.push_front(code(int'(pos) - int'(neg)));
        pos <= (i % 4 == 0) ? 12'(tbl[(i / 4) % 5]) : 12'($urandom_range(800) - 400);
        neg <= (i % 4 == 0) ? 12'h000 : 12'($urandom_range(400) - 200);
        i++;
    endtask : step
    // expected secondary word for a fresh load
    function automatic logic [7:0] sec_exp(input logic [2:0] m);
        return m[0] ? 8'(h[L]) : ((m[2] && !m[1]) ? 8'(h[L + 1]) : IDLE_WORD);
    endfunction : sec_exp
    task automatic run_mode(input logic [2:0] m);
        int n;
        int r0;
        logic got;
        logic [7:0] ep;
        logic [7:0] es;
        logic [7:0] lp;
        n = m[2] ? (m[1] ? DIV5_COUNT : DIV2_COUNT) : 1;
        got = 1'b0;
        {dv, rt, mr} <= m;
        rst <= 1'b1;
        repeat (6) step();
        rst <= 1'b0;
        repeat (12) step();
        // lock on a load edge: the word must have just changed, so equal saturated codes cannot fake it
        lp = pri;
        for (int j = 0; j < 8 * n && !got; j++) begin
            step();
            got = pri !== lp && pri === 8'(h[L]) && sec === sec_exp(m);
            lp = pri;
        end
        if (!got) begin
            fails++;
            final_report();
        end
        ep = pri;
        es = sec;
        r0 = rises;
        for (int j = 1; j <= 50; j++) begin
            step();
            if (j % n == 0) begin
                ep = 8'(h[L]);
                es = sec_exp(m);
            end
            check(pri, ep);
            check(sec, es);
        end
        check(rises - r0, 50 / n);
    endtask : run_mode
    // every pin combination, ratio pin included where it is ignored
    initial begin
        void'($urandom(97302));
        for (int m = 0; m < 8; m++) begin
            run_mode(3'(m));
        end
        final_report();
    end
endmodule : test_adc_output_path_mode_ctrl
`default_nettype wire
